// ==== shared/fault_mgr_defines.svh ====
// Timing constants and register map of the hot-swap output fault manager
`ifndef FAULT_MGR_DEFINES_SVH
`define FAULT_MGR_DEFINES_SVH
`define CLK_FREQ_HZ 200000000
`define START_MIN_NS 450000
`define START_MAX_NS 50000000
`define START_DEFAULT_NS 9000000
`define RETRY_MULT 64
`define GLITCH_NS 20000
`define GLITCH_CYC ((`GLITCH_NS * 64'd200) / 64'd1000)
`define CLEAR_HOLD_NS 100000
`define CLEAR_HOLD_CYC ((`CLEAR_HOLD_NS * 64'd200 + 64'd999) / 64'd1000)
`define PG_DELAY_NS 750000
`define PG_DELAY_CYC ((`PG_DELAY_NS * 64'd200 + 64'd999) / 64'd1000)
`define NS_TO_CYC(ns) ((64'(ns) * 64'd200 + 64'd999) / 64'd1000)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_START_NS 8'h10
`define CTRL_PROTECT_BIT 0
`define CTRL_AUTORETRY_BIT 1
`define CTRL_RESET 32'h0000_0003
`define IRQ_BITS 4
`endif

// ==== shared/fault_mgr_pkg.sv ====
// Types shared by the fault manager design
package fault_mgr_pkg;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_START = 3'b001,
      ST_PG_WAIT = 3'b010,
      ST_RUN = 3'b011,
      ST_LATCHED = 3'b100,
      ST_RETRY = 3'b101
   } seq_state_t;
endpackage : fault_mgr_pkg

// ==== design/sync_filter.sv ====
// Two-flop synchroniser with persistence filter for one input
`timescale 1ns/10ps
`default_nettype none
module sync_filter #(
   parameter int CNT_W = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic din,
   input wire logic [CNT_W-1:0] persist,
   output logic sync_out,
   output logic filt_out
);
   logic meta_ff;
   logic sync_ff;
   logic filt_ff;
   logic [CNT_W-1:0] cnt_ff;
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else if (ce) begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
   // Only the rise must persist; release follows at once so a cleared fault frees power-good
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_ff <= '0;
         filt_ff <= 1'b0;
      end else if (ce) begin
         if (!sync_ff) begin
            filt_ff <= 1'b0;
            cnt_ff <= '0;
         end else if (filt_ff) cnt_ff <= '0;
         else if (cnt_ff >= persist) begin
            filt_ff <= 1'b1;
            cnt_ff <= '0;
         end else cnt_ff <= cnt_ff + 1'b1;
      end
   end
   assign sync_out = sync_ff;
   assign filt_out = filt_ff;
endmodule : sync_filter
`default_nettype wire

// ==== design/down_timer.sv ====
// Loadable down counter with done flag
`timescale 1ns/10ps
`default_nettype none
module down_timer #(
   parameter int W = 40
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] cnt_ff;
   always_ff @(posedge mclk) begin
      if (rst) cnt_ff <= '0;
      else if (ce) begin
         if (load) cnt_ff <= value;
         else if (cnt_ff != '0) cnt_ff <= cnt_ff - 1'b1;
      end
   end
   assign done = (cnt_ff == '0) && !load;
endmodule : down_timer
`default_nettype wire

// ==== design/hot_swap_output_fault_manager.sv ====
// Dual-channel hot-swap fault manager with startup timer and power-good control
`timescale 1ns/10ps
`default_nettype none
`include "fault_mgr_defines.svh"
// Function
// - Output monitors stay disarmed during startup, armed once startup period expires.
// - Armed monitor faults when level is below lower or above upper window bound.
// - Protection variant: voltage fault turns off both gates and lowers both power-goods.
// - Autoretry: restart attempted each retry delay, succeeds only when fault gone.
// - Latching: gates stay off until fault gone and latch cleared by toggle or lockout.
// - Monitoring variant: voltage fault keeps gates, lowers only faulted channel power-good.
// - Monitoring variant: power-good released immediately once that channel's fault clears.
// - Out-of-window excursions shorter than twenty microseconds are ignored.
// - Power-good low whenever overcurrent or voltage fault applies to the channel.
// - Power-good low while that channel's enable input is low, channel forced off.
// - Startup period configurable 0.45 to 50 ms, default nine milliseconds.
// - Overcurrent on either channel turns off both gates, lowers both power-goods.
// - Autoretry delay equals sixty-four startup periods.
// - Latch clears only after enable low or lockout held at least 100 us.
// - Power-good released 0.75 ms after startup ends if channel fault free.
module hot_swap_output_fault_manager #(
   parameter int TW = 40,
   parameter longint START_DEFAULT_CYC = `NS_TO_CYC(`START_DEFAULT_NS),
   parameter longint CLEAR_HOLD_CYC = `CLEAR_HOLD_CYC,
   parameter longint PG_DELAY_CYC = `PG_DELAY_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic uvlo_ok,
   input wire logic channel_enable_in_1,
   input wire logic channel_enable_in_2,
   input wire logic output_monitor_ch1_low,
   input wire logic output_monitor_ch1_high,
   input wire logic output_monitor_ch2_low,
   input wire logic output_monitor_ch2_high,
   input wire logic overcurrent_ch1,
   input wire logic overcurrent_ch2,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic pass_gate_drive_ch1,
   output logic pass_gate_drive_ch2,
   output logic strong_discharge,
   output logic power_good_ch1_o,
   output logic power_good_ch1_oe_n,
   output logic power_good_ch2_o,
   output logic power_good_ch2_oe_n,
   output logic irq
);
   // Timer width must hold the longest retry delay and fit the read-back word
   if (TW < 32 || TW > 48) begin : g_bad_tw
      $error("TW out of range");
   end
   if (CLEAR_HOLD_CYC < 1 || PG_DELAY_CYC < 1) begin : g_bad_cnt
      $error("Counts must be at least one");
   end

   localparam logic [TW-1:0] START_MIN_CYC = TW'(`NS_TO_CYC(`START_MIN_NS));
   localparam logic [TW-1:0] START_MAX_CYC = TW'(`NS_TO_CYC(`START_MAX_NS));

   // Input conditioning
   logic [5:0] raw_in;
   logic [5:0] sync_v;
   logic [5:0] filt_v;
   logic [TW-1:0] persist_v [6];
   assign raw_in = {overcurrent_ch2, overcurrent_ch1, output_monitor_ch2_low | output_monitor_ch2_high,
                    output_monitor_ch1_low | output_monitor_ch1_high, channel_enable_in_2, channel_enable_in_1};
   // Enable inputs take no hold, monitors the glitch window, overcurrent passes through
   assign persist_v[0] = '0;
   assign persist_v[1] = '0;
   assign persist_v[2] = TW'(`GLITCH_CYC);
   assign persist_v[3] = TW'(`GLITCH_CYC);
   assign persist_v[4] = '0;
   assign persist_v[5] = '0;
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_in
         sync_filter #(.CNT_W(TW)) u_sf (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .din(raw_in[gi]),
            .persist(persist_v[gi]),
            .sync_out(sync_v[gi]),
            .filt_out(filt_v[gi])
         );
      end
   endgenerate
   logic uvlo_meta_ff;
   logic uvlo_ff;
   always_ff @(posedge mclk) begin
      if (rst) begin
         uvlo_meta_ff <= 1'b0;
         uvlo_ff <= 1'b0;
      end else if (ce) begin
         uvlo_meta_ff <= uvlo_ok;
         uvlo_ff <= uvlo_meta_ff;
      end
   end

   wire logic en1 = sync_v[0];
   wire logic en2 = sync_v[1];
   wire logic oc_any = sync_v[4] | sync_v[5];

   // Registers
   logic [31:0] ctrl_ff;
   logic [TW-1:0] start_cfg_ff;
   logic [`IRQ_BITS-1:0] irq_stat_ff;
   logic [`IRQ_BITS-1:0] irq_mask_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   wire logic protect = ctrl_ff[`CTRL_PROTECT_BIT];
   wire logic autoretry = ctrl_ff[`CTRL_AUTORETRY_BIT];

   wire logic bus_req = wb_cyc_i & wb_stb_i & !ack_ff;
   wire logic hit_ctrl = wb_adr_i == `REG_CTRL;
   wire logic hit_stat = wb_adr_i == `REG_STATUS;
   wire logic hit_istat = wb_adr_i == `REG_IRQ_STAT;
   wire logic hit_imask = wb_adr_i == `REG_IRQ_MASK;
   wire logic hit_start = wb_adr_i == `REG_START_NS;
   wire logic hit_any = hit_ctrl | hit_stat | hit_istat | hit_imask | hit_start;
   wire logic wr = bus_req & wb_we_i & wb_sel_i[0];
   wire logic wr_ctrl = wr & hit_ctrl;
   wire logic wr_istat = wr & hit_istat;
   wire logic wr_imask = wr & hit_imask;
   wire logic wr_start = bus_req & wb_we_i & hit_start & (&wb_sel_i);

   // Startup period clamped into its legal range, zero means default
   logic [TW-1:0] wr_start_cyc;
   assign wr_start_cyc = TW'(`NS_TO_CYC(wb_dat_i));
   wire logic [TW-1:0] start_clamped = (wb_dat_i == 32'h0000_0000) ? TW'(START_DEFAULT_CYC) :
                                       (wr_start_cyc < START_MIN_CYC) ? START_MIN_CYC :
                                       (wr_start_cyc > START_MAX_CYC) ? START_MAX_CYC : wr_start_cyc;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_ff <= `CTRL_RESET;
         start_cfg_ff <= TW'(START_DEFAULT_CYC);
         irq_mask_ff <= '0;
      end else if (ce) begin
         if (wr_ctrl) ctrl_ff <= {30'h0000_0000, wb_dat_i[1:0]};
         if (wr_start) start_cfg_ff <= start_clamped;
         if (wr_imask) irq_mask_ff <= wb_dat_i[`IRQ_BITS-1:0];
      end
   end

   // Sequencer
   fault_mgr_pkg::seq_state_t state_ff, nxt_state;
   logic tmr_load;
   logic [TW-1:0] tmr_value;
   logic tmr_done;
   logic clr_load;
   logic clr_done;
   logic pg_load;
   logic pg_done;

   down_timer #(.W(TW)) u_seq_tmr (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .load(tmr_load),
      .value(tmr_value),
      .done(tmr_done)
   );
   // Hold timer for latch clearing: restarts while enables and supply look healthy
   wire logic clr_cond = !en1 | !en2 | !uvlo_ff;
   assign clr_load = !clr_cond;
   down_timer #(.W(TW)) u_clr_tmr (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .load(clr_load),
      .value(TW'(CLEAR_HOLD_CYC)),
      .done(clr_done)
   );
   logic clr_seen_ff;
   always_ff @(posedge mclk) begin
      if (rst) clr_seen_ff <= 1'b0;
      else if (ce) begin
         if (state_ff != fault_mgr_pkg::ST_LATCHED) clr_seen_ff <= 1'b0;
         else if (clr_done) clr_seen_ff <= 1'b1;
      end
   end
   assign pg_load = state_ff == fault_mgr_pkg::ST_START;
   down_timer #(.W(TW)) u_pg_tmr (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .load(pg_load),
      .value(TW'(PG_DELAY_CYC)),
      .done(pg_done)
   );

   wire logic armed = (state_ff == fault_mgr_pkg::ST_PG_WAIT) || (state_ff == fault_mgr_pkg::ST_RUN);
   wire logic vf1 = armed & filt_v[2];
   wire logic vf2 = armed & filt_v[3];
   wire logic trip = oc_any | (protect & (vf1 | vf2));
   wire logic [TW-1:0] retry_cyc = TW'(start_cfg_ff * `RETRY_MULT);
   wire logic both_on = en1 & en2 & uvlo_ff;

   always_comb begin
      nxt_state = state_ff;
      tmr_load = 1'b0;
      tmr_value = start_cfg_ff;
      unique case (state_ff)
         fault_mgr_pkg::ST_OFF: begin
            if (both_on) begin
               nxt_state = fault_mgr_pkg::ST_START;
               tmr_load = 1'b1;
            end
         end
         fault_mgr_pkg::ST_START: begin
            if (!both_on) nxt_state = fault_mgr_pkg::ST_OFF;
            else if (tmr_done) nxt_state = fault_mgr_pkg::ST_PG_WAIT;
         end
         fault_mgr_pkg::ST_PG_WAIT, fault_mgr_pkg::ST_RUN: begin
            if (!uvlo_ff) nxt_state = fault_mgr_pkg::ST_OFF;
            else if (trip) begin
               nxt_state = autoretry ? fault_mgr_pkg::ST_RETRY : fault_mgr_pkg::ST_LATCHED;
               tmr_load = 1'b1;
               tmr_value = retry_cyc;
            end else if (!both_on) nxt_state = fault_mgr_pkg::ST_OFF;
            else if (state_ff == fault_mgr_pkg::ST_PG_WAIT && pg_done) nxt_state = fault_mgr_pkg::ST_RUN;
         end
         fault_mgr_pkg::ST_RETRY: begin
            // Supply cycling overrides the wait; enable toggles do not
            if (!uvlo_ff) nxt_state = fault_mgr_pkg::ST_OFF;
            else if (tmr_done) begin
               // Rails are off here and read below window; the restart re-arms and judges them anew
               if (oc_any) begin
                  tmr_load = 1'b1;
                  tmr_value = retry_cyc;
               end else nxt_state = fault_mgr_pkg::ST_OFF;
            end
         end
         fault_mgr_pkg::ST_LATCHED: begin
            if (clr_seen_ff && !oc_any) nxt_state = fault_mgr_pkg::ST_OFF;
         end
         default: nxt_state = fault_mgr_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) state_ff <= fault_mgr_pkg::ST_OFF;
      else if (ce) state_ff <= nxt_state;
   end

   // Outputs
   wire logic fault_state = (state_ff == fault_mgr_pkg::ST_LATCHED) || (state_ff == fault_mgr_pkg::ST_RETRY);
   wire logic gate_on = (state_ff == fault_mgr_pkg::ST_START) || armed;
   wire logic g1 = gate_on & en1 & !trip;
   wire logic g2 = gate_on & en2 & !trip;
   wire logic pg1 = (state_ff == fault_mgr_pkg::ST_RUN) & en1 & !oc_any & !vf1 & !(protect & vf2);
   wire logic pg2 = (state_ff == fault_mgr_pkg::ST_RUN) & en2 & !oc_any & !vf2 & !(protect & vf1);
   logic g1_ff;
   logic g2_ff;
   logic dis_ff;
   logic pg1_ff;
   logic pg2_ff;
   always_ff @(posedge mclk) begin
      if (rst) begin
         g1_ff <= 1'b0;
         g2_ff <= 1'b0;
         dis_ff <= 1'b0;
         pg1_ff <= 1'b0;
         pg2_ff <= 1'b0;
      end else if (ce) begin
         g1_ff <= g1;
         g2_ff <= g2;
         dis_ff <= fault_state | trip;
         pg1_ff <= pg1;
         pg2_ff <= pg2;
      end
   end
   assign pass_gate_drive_ch1 = g1_ff;
   assign pass_gate_drive_ch2 = g2_ff;
   assign strong_discharge = dis_ff;
   assign power_good_ch1_o = 1'b0;
   assign power_good_ch2_o = 1'b0;
   // Open drain: enable low pulls the pin, high releases it
   assign power_good_ch1_oe_n = pg1_ff;
   assign power_good_ch2_oe_n = pg2_ff;

   // Interrupts: overcurrent, voltage ch1, voltage ch2, latch/retry entry
   wire logic [`IRQ_BITS-1:0] ev = {trip & armed, vf2, vf1, oc_any & armed};
   always_ff @(posedge mclk) begin
      if (rst) irq_stat_ff <= '0;
      else if (ce) irq_stat_ff <= (irq_stat_ff & ~(wr_istat ? wb_dat_i[`IRQ_BITS-1:0] : '0)) | ev;
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);

   // Wishbone read and ack
   wire logic [31:0] status_word = {24'h00_0000, 2'b00, state_ff, pg2_ff, pg1_ff, armed};
   wire logic [31:0] rd_mux = hit_ctrl ? ctrl_ff :
                              hit_stat ? status_word :
                              hit_istat ? {28'h000_0000, irq_stat_ff} :
                              hit_imask ? {28'h000_0000, irq_mask_ff} :
                              hit_start ? 32'(start_cfg_ff) : 32'h0000_0000;
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_ff <= 1'b0;
         rdata_ff <= '0;
      end else if (ce) begin
         ack_ff <= bus_req & hit_any;
         rdata_ff <= rd_mux;
      end
   end
   logic err_ff;
   always_ff @(posedge mclk) begin
      if (rst) err_ff <= 1'b0;
      else if (ce) err_ff <= bus_req & !hit_any & !err_ff;
   end
   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;
   assign wb_dat_o = rdata_ff;
endmodule : hot_swap_output_fault_manager
`default_nettype wire

// ==== tb/hot_swap_far_side_model.sv ====
// Far-side model: pass transistors with output ramp and pulled-up power-good pins
`timescale 1ns/10ps
`default_nettype none
module hot_swap_far_side_model #(
   parameter int RAMP_CYC = 20
) (
   input wire logic mclk,
   input wire logic gate_1,
   input wire logic gate_2,
   input wire logic pg_o_1,
   input wire logic pg_oe_n_1,
   input wire logic pg_o_2,
   input wire logic pg_oe_n_2,
   input wire logic [3:0] inject,
   output logic [3:0] mon_flags,
   output logic pg_pin_1,
   output logic pg_pin_2
);
   int ramp_1_ff = 0;
   int ramp_2_ff = 0;
   // Rail reads below window while its gate is off; ramp kept shorter than startup
   always_ff @(posedge mclk) begin
      ramp_1_ff <= !gate_1 ? 0 : (ramp_1_ff < RAMP_CYC) ? ramp_1_ff + 1 : ramp_1_ff;
      ramp_2_ff <= !gate_2 ? 0 : (ramp_2_ff < RAMP_CYC) ? ramp_2_ff + 1 : ramp_2_ff;
   end
   // Order: ch1 low, ch1 high, ch2 low, ch2 high; bench faults add on top
   assign mon_flags = inject | {1'h0, ramp_2_ff < RAMP_CYC, 1'h0, ramp_1_ff < RAMP_CYC};
   // Pull-ups: a released pin reads high
   assign pg_pin_1 = pg_oe_n_1 ? 1'h1 : pg_o_1;
   assign pg_pin_2 = pg_oe_n_2 ? 1'h1 : pg_o_2;
endmodule : hot_swap_far_side_model
`default_nettype wire

// ==== tb/hot_swap_output_fault_manager_asserts.sv ====
// Port-level assertions for the hot-swap output fault manager
`timescale 1ns/10ps
`default_nettype none
module hot_swap_output_fault_manager_asserts #(
   parameter longint PG_DELAY_CYC = 10
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic channel_enable_in_1,
   input wire logic output_monitor_ch1_low,
   input wire logic output_monitor_ch1_high,
   input wire logic overcurrent_ch1,
   input wire logic overcurrent_ch2,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic pass_gate_drive_ch1,
   input wire logic pass_gate_drive_ch2,
   input wire logic power_good_ch1_oe_n,
   input wire logic power_good_ch2_oe_n
);
   logic [15:0] exc_ff;
   logic [15:0] gon_ff;
   logic ex_1;
   logic oc_any;
   assign ex_1 = output_monitor_ch1_low | output_monitor_ch1_high;
   assign oc_any = overcurrent_ch1 | overcurrent_ch2;
   // Saturating run lengths; they stop rather than wrap
   always_ff @(posedge mclk) begin
      exc_ff <= (rst | !ex_1) ? 16'h0 : exc_ff + {15'h0, ~&exc_ff};
      gon_ff <= (rst | !pass_gate_drive_ch1) ? 16'h0 : gon_ff + {15'h0, ~&gon_ff};
   end
   default clocking dck @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_oc_trip_all: assert property ($rose(oc_any) && power_good_ch1_oe_n |-> ##[1:5]
      !(pass_gate_drive_ch1 | pass_gate_drive_ch2 | power_good_ch1_oe_n | power_good_ch2_oe_n))
      else $error("overcurrent left a channel up");
   a_pg_off_disabled: assert property (!channel_enable_in_1 [*5] |-> !power_good_ch1_oe_n)
      else $error("power-good released while disabled");
   a_gate_off_disabled: assert property (!channel_enable_in_1 [*5] |-> !pass_gate_drive_ch1)
      else $error("gate on while disabled");
   // Filter needs 4000 cycles; margin covers the synchroniser
   a_pg_fall_cause: assert property ($fell(power_good_ch1_oe_n) |->
      exc_ff > 16'h0F96 || oc_any || !channel_enable_in_1)
      else $error("power-good dropped without cause");
   a_pg_rise_delay: assert property ($rose(power_good_ch1_oe_n) |-> gon_ff >= 16'(PG_DELAY_CYC))
      else $error("power-good released too early");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
      else $error("bus answer late");
   a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
      else $error("ack and err together");
   c_trip: cover property ($fell(pass_gate_drive_ch1));
   c_release: cover property ($rose(power_good_ch1_oe_n));
   c_err: cover property (wb_err_o);
endmodule : hot_swap_output_fault_manager_asserts
bind hot_swap_output_fault_manager hot_swap_output_fault_manager_asserts #(.PG_DELAY_CYC(PG_DELAY_CYC)) u_chk (
   .mclk(mclk), .rst(rst), .channel_enable_in_1(channel_enable_in_1),
   .output_monitor_ch1_low(output_monitor_ch1_low), .output_monitor_ch1_high(output_monitor_ch1_high),
   .overcurrent_ch1(overcurrent_ch1), .overcurrent_ch2(overcurrent_ch2), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pass_gate_drive_ch1(pass_gate_drive_ch1),
   .pass_gate_drive_ch2(pass_gate_drive_ch2), .power_good_ch1_oe_n(power_good_ch1_oe_n),
   .power_good_ch2_oe_n(power_good_ch2_oe_n));
`default_nettype wire

// ==== tb/hot_swap_output_fault_manager_tb_top.sv ====
// Self-checking bench for the hot-swap output fault manager
`timescale 1ns/10ps
`default_nettype none
module hot_swap_output_fault_manager_tb_top;
   localparam int ST = 50;
   localparam int PGD = 10;
   localparam int CLR = 5;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic uvlo_ok = 1'h0;
   logic en_1 = 1'h0;
   logic en_2 = 1'h0;
   logic [1:0] oc = 2'h0;
   logic [3:0] inject = 4'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic we = 1'h0;
   logic cyc = 1'h0;
   logic [3:0] mon;
   logic [31:0] rdat;
   logic ack, err, g_1, g_2, dis, pgo_1, pgoe_1, pgo_2, pgoe_2, irq, pin_1, pin_2;
   int failures = 0;
   int num_checks = 0;
   int n;
   hot_swap_output_fault_manager #(.START_DEFAULT_CYC(ST), .CLEAR_HOLD_CYC(CLR), .PG_DELAY_CYC(PGD)) u_dut (
      .mclk(mclk), .rst(rst), .ce(1'h1), .uvlo_ok(uvlo_ok), .channel_enable_in_1(en_1), .channel_enable_in_2(en_2),
      .output_monitor_ch1_low(mon[0]), .output_monitor_ch1_high(mon[1]), .output_monitor_ch2_low(mon[2]),
      .output_monitor_ch2_high(mon[3]), .overcurrent_ch1(oc[0]), .overcurrent_ch2(oc[1]), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .pass_gate_drive_ch1(g_1), .pass_gate_drive_ch2(g_2),
      .strong_discharge(dis), .power_good_ch1_o(pgo_1), .power_good_ch1_oe_n(pgoe_1), .power_good_ch2_o(pgo_2),
      .power_good_ch2_oe_n(pgoe_2), .irq(irq));
   hot_swap_far_side_model u_far (.mclk(mclk), .gate_1(g_1), .gate_2(g_2), .pg_o_1(pgo_1), .pg_oe_n_1(pgoe_1),
      .pg_o_2(pgo_2), .pg_oe_n_2(pgoe_2), .inject(inject), .mon_flags(mon), .pg_pin_1(pin_1), .pg_pin_2(pin_2));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic timeout(input string what);
      failures++;
      $display("Error %0t: timeout in %s", $time, what);
      report_and_stop();
   endtask : timeout
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int i;
      @(posedge mclk);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'h1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (ack === 1'h1 || err === 1'h1) break;
      end
      if (i == 20) timeout("bus");
      q = rdat;
      e = err;
      cyc <= 1'h0;
   endtask : bus
   function automatic logic pick(input int s);
      return (s == 0) ? pin_1 : (s == 1) ? pin_2 : g_1;
   endfunction : pick
   // Bounded wait; n returns the edges taken
   task automatic wait_sig(input int s, input logic v, input int lim);
      n = 0;
      while (pick(s) !== v) begin
         @(posedge mclk);
         n++;
         if (n > lim) timeout("wait");
      end
   endtask : wait_sig
   // Startup setting: zero gives the default, else 5 ns per cycle clamped to 0.45..50 ms
   function automatic logic [31:0] exp_start(input logic [31:0] ns);
      longint c;
      c = (longint'(ns) + 4) / 5;
      if (ns == 32'h0) return 32'(ST);
      return (c < 90000) ? 32'h0001_5F90 : (c > 10000000) ? 32'h0098_9680 : 32'(c);
   endfunction : exp_start
   function automatic int retry_cyc(input int start);
      return 64 * start;
   endfunction : retry_cyc
   initial begin
      logic e;
      logic [31:0] rd;
      logic [31:0] wd;
      longint t0;
      int el;
      void'($urandom(95769));
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      chk({pin_1, pin_2, g_1, g_2}, 32'h0, "reset outputs");
      bus(8'h00, 1'h0, 32'h0, rd, e);
      chk(rd, 32'h3, "ctrl default");
      bus(8'h24, 1'h0, 32'h0, rd, e);
      chk(e, 32'h1, "unmapped read");
      // Below minimum, inside range, random wide value, then zero to restore the default
      for (int k = 0; k < 4; k++) begin
         wd = (k == 0) ? $urandom_range(449999) : (k == 1) ? 450000 + $urandom_range(49550000) :
              (k == 2) ? $urandom : 32'h0;
         bus(8'h10, 1'h1, wd, rd, e);
         bus(8'h10, 1'h0, 32'h0, rd, e);
         chk(rd, exp_start(wd), "startup setting");
      end
      bus(8'h0C, 1'h1, 32'hF, rd, e);
      uvlo_ok <= 1'h1;
      en_1 <= 1'h1;
      en_2 <= 1'h1;
      wait_sig(0, 1'h1, 200);
      chk(n >= ST + PGD && n < ST + PGD + 20, 32'h1, "startup length");
      bus(8'h04, 1'h0, 32'h0, rd, e);
      chk({rd[0], pin_2}, 32'h3, "armed");
      // Excursions kept under the filter length must pass unseen
      for (int k = 0; k < 3; k++) begin
         inject <= 4'(4'h1 << $urandom_range(3));
         repeat (200 + $urandom_range(3500)) @(posedge mclk);
         inject <= 4'h0;
         repeat (10) @(posedge mclk);
         chk({pin_1, pin_2}, 32'h3, "short excursion");
      end
      inject <= 4'h2;
      wait_sig(2, 1'h0, 4100);
      t0 = $time;
      chk(n > 3990, 32'h1, "filter length");
      repeat (2) @(posedge mclk);
      chk({g_2, pin_1, pin_2, dis, irq}, 32'h3, "protection trip");
      inject <= 4'h0;
      bus(8'h08, 1'h0, 32'h0, rd, e);
      chk(rd[1], 32'h1, "fault event");
      bus(8'h0C, 1'h1, 32'h0, rd, e);
      @(posedge mclk);
      chk(irq, 32'h0, "masked irq");
      bus(8'h08, 1'h1, 32'hF, rd, e);
      bus(8'h0C, 1'h1, 32'hF, rd, e);
      bus(8'h08, 1'h0, 32'h0, rd, e);
      chk(rd[1], 32'h0, "event cleared");
      wait_sig(0, 1'h1, retry_cyc(ST) + 200);
      el = int'(($time - t0) / 5);
      chk(el >= retry_cyc(ST) && el < retry_cyc(ST) + ST + PGD + 40, 32'h1, "retry timing");
      bus(8'h00, 1'h1, 32'h0, rd, e);
      inject <= 4'h4;
      wait_sig(1, 1'h0, 4100);
      repeat (2) @(posedge mclk);
      chk({pin_1, g_1, g_2}, 32'h7, "monitor keeps gates");
      inject <= 4'h0;
      wait_sig(1, 1'h1, 8);
      oc <= 2'(2'h1 << $urandom_range(1));
      repeat (10) @(posedge mclk);
      oc <= 2'h0;
      chk({g_1, g_2, pin_1, pin_2}, 32'h0, "overcurrent trip");
      repeat (200) @(posedge mclk);
      en_1 <= 1'h0;
      repeat (2) @(posedge mclk);
      en_1 <= 1'h1;
      repeat (200) @(posedge mclk);
      chk(g_1, 32'h0, "latch held");
      en_1 <= 1'h0;
      repeat (CLR + 10) @(posedge mclk);
      chk(pin_1, 32'h0, "disabled channel");
      en_1 <= 1'h1;
      bus(8'h04, 1'h0, 32'h0, rd, e);
      chk(rd[0], 32'h0, "disarmed in startup");
      wait_sig(0, 1'h1, 400);
      report_and_stop();
   end
endmodule : hot_swap_output_fault_manager_tb_top
`default_nettype wire
